/* core/tcc_defines.svh */
// register indices, field positions, reset values and timing counts of the capture/compare block
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_ADR_W 18
`define TCC_IDX_CAP_VAL_A 16'h4502
`define TCC_IDX_CAP_VAL_B 16'h4504
`define TCC_IDX_CMP_VAL_A 16'h4508
`define TCC_IDX_CMP_VAL_B 16'h450a
`define TCC_IDX_CMP_CFG_A 16'h450e
`define TCC_IDX_CMP_CFG_B 16'h4510
`define TCC_IDX_CAP_CFG_A 16'h4512
`define TCC_IDX_CAP_CFG_B 16'h4514
`define TCC_IDX_INT_STATUS 16'h4520
`define TCC_IDX_INT_CLEAR 16'h4522
`define TCC_IDX_INT_ENABLE 16'h4524
`define TCC_CMP_EN_BIT 15
`define TCC_CMP_INV_BIT 4
`define TCC_CMP_MODE_MSB 3
`define TCC_CMP_MODE_LSB 0
`define TCC_CAP_FILT_BIT 8
`define TCC_CAP_EDGE_MSB 6
`define TCC_CAP_EDGE_LSB 5
`define TCC_RST_16 16'h0000
`define TCC_FILT_LEN 4
`define TCC_ST_CMP_A 0
`define TCC_ST_CMP_B 1
`define TCC_ST_CAP_A 2
`define TCC_ST_CAP_B 3
`endif

/* core/tcc_pkg.sv */
// types of the capture/compare block
package tcc_pkg;
    typedef enum logic [3:0] {
        TCC_EDGE_OFF = 4'h1,
        TCC_EDGE_RISE = 4'h2,
        TCC_EDGE_FALL = 4'h4,
        TCC_EDGE_BOTH = 4'h8
    } tcc_edge_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic [1:0] cmp_out;
        logic [1:0] cmp_en;
        logic [1:0] cmp_inv;
        logic [1:0][3:0] cmp_mode;
        logic [1:0][15:0] cmp_val;
        logic [1:0] wave;
        logic [1:0] match_d;
        logic [1:0] cap_filt;
        logic [1:0][1:0] cap_edge;
        logic [1:0][15:0] cap_val;
        logic [1:0][3:0] shreg;
        logic [1:0] filt;
        logic [1:0] prev;
        logic [3:0] status;
        logic [3:0] int_en;
    } tcc_state_type;
endpackage : tcc_pkg

/* core/tcc_channels.sv */
// two compare outputs and two capture inputs behind a classic wishbone slave
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`include "tcc_defines.svh"

module tcc_channels import tcc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`TCC_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [15:0] count_i,
    input wire logic [1:0] cap_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    output logic [1:0] cmp_out_o
);

    tcc_state_type st_ff;
    tcc_state_type nxt_st;
    logic [3:0] ev;
    logic [3:0] clr;
    logic req;

    function automatic logic hit(input logic [`TCC_ADR_W-1:0] adr, input logic [15:0] idx);
        hit = (adr[`TCC_ADR_W-1:2] == idx);
    endfunction : hit

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
        merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction : merge

    function automatic tcc_edge_type edge_code(input logic [1:0] sel);
        case (sel)
            2'h1: edge_code = TCC_EDGE_RISE;
            2'h2: edge_code = TCC_EDGE_FALL;
            2'h3: edge_code = TCC_EDGE_BOTH;
            default: edge_code = TCC_EDGE_OFF;
        endcase
    endfunction : edge_code

    always_comb begin
        logic sig;
        logic match;
        logic [15:0] rd;
        logic [15:0] wv;
        logic ci;
        logic ki;
        nxt_st = st_ff;
        sig = 1'b0;
        match = 1'b0;
        rd = `TCC_RST_16;
        wv = `TCC_RST_16;
        // channel from a full index match: config a and b indices differ in more than one bit
        ci = hit(adr_i, `TCC_IDX_CMP_CFG_B);
        ki = hit(adr_i, `TCC_IDX_CAP_CFG_B);
        ev = 4'h0;
        clr = 4'h0;
        req = cyc_i & stb_i & ~st_ff.ack;
        // answer one cycle after the request, drop ack the cycle after
        nxt_st.ack = req;
        nxt_st.dat = 32'h0000_0000;
        if (req && !we_i) begin
            if (hit(adr_i, `TCC_IDX_CAP_VAL_A)) begin
                rd = st_ff.cap_val[0];
            end else if (hit(adr_i, `TCC_IDX_CAP_VAL_B)) begin
                rd = st_ff.cap_val[1];
            end else if (hit(adr_i, `TCC_IDX_CMP_VAL_A)) begin
                rd = st_ff.cmp_val[0];
            end else if (hit(adr_i, `TCC_IDX_CMP_VAL_B)) begin
                rd = st_ff.cmp_val[1];
            end else if (hit(adr_i, `TCC_IDX_CMP_CFG_A) || hit(adr_i, `TCC_IDX_CMP_CFG_B)) begin
                rd[`TCC_CMP_EN_BIT] = st_ff.cmp_en[ci];
                rd[`TCC_CMP_INV_BIT] = st_ff.cmp_inv[ci];
                rd[`TCC_CMP_MODE_MSB:`TCC_CMP_MODE_LSB] = st_ff.cmp_mode[ci];
            end else if (hit(adr_i, `TCC_IDX_CAP_CFG_A) || hit(adr_i, `TCC_IDX_CAP_CFG_B)) begin
                rd[`TCC_CAP_FILT_BIT] = st_ff.cap_filt[ki];
                rd[`TCC_CAP_EDGE_MSB:`TCC_CAP_EDGE_LSB] = st_ff.cap_edge[ki];
            end else if (hit(adr_i, `TCC_IDX_INT_STATUS)) begin
                rd[3:0] = st_ff.status;
            end else if (hit(adr_i, `TCC_IDX_INT_ENABLE)) begin
                rd[3:0] = st_ff.int_en;
            end
            nxt_st.dat = {16'h0000, rd};
        end
        if (req && we_i) begin
            // capture values and status are read-only: no write branch for them
            if (hit(adr_i, `TCC_IDX_CMP_VAL_A)) begin
                nxt_st.cmp_val[0] = merge(st_ff.cmp_val[0], dat_i, sel_i);
            end
            if (hit(adr_i, `TCC_IDX_CMP_VAL_B)) begin
                nxt_st.cmp_val[1] = merge(st_ff.cmp_val[1], dat_i, sel_i);
            end
            if (hit(adr_i, `TCC_IDX_CMP_CFG_A) || hit(adr_i, `TCC_IDX_CMP_CFG_B)) begin
                wv = merge({st_ff.cmp_en[ci], 10'h000, st_ff.cmp_inv[ci],
                            st_ff.cmp_mode[ci]}, dat_i, sel_i);
                nxt_st.cmp_en[ci] = wv[`TCC_CMP_EN_BIT];
                nxt_st.cmp_inv[ci] = wv[`TCC_CMP_INV_BIT];
                nxt_st.cmp_mode[ci] = wv[`TCC_CMP_MODE_MSB:`TCC_CMP_MODE_LSB];
            end
            if (hit(adr_i, `TCC_IDX_CAP_CFG_A) || hit(adr_i, `TCC_IDX_CAP_CFG_B)) begin
                wv = merge({7'h00, st_ff.cap_filt[ki], 1'b0, st_ff.cap_edge[ki], 5'h00},
                           dat_i, sel_i);
                nxt_st.cap_filt[ki] = wv[`TCC_CAP_FILT_BIT];
                nxt_st.cap_edge[ki] = wv[`TCC_CAP_EDGE_MSB:`TCC_CAP_EDGE_LSB];
            end
            if (hit(adr_i, `TCC_IDX_INT_CLEAR) && sel_i[0]) begin
                clr = dat_i[3:0];
            end
            if (hit(adr_i, `TCC_IDX_INT_ENABLE) && sel_i[0]) begin
                nxt_st.int_en = dat_i[3:0];
            end
        end
        for (int i = 0; i < 2; i++) begin
            // compare: act once per arrival at the value, not every cycle it is held
            match = (count_i == st_ff.cmp_val[i]);
            nxt_st.match_d[i] = match;
            if (match && !st_ff.match_d[i]) begin
                ev[`TCC_ST_CMP_A + i] = 1'b1;
                case (st_ff.cmp_mode[i])
                    4'h1: nxt_st.wave[i] = 1'b1;
                    4'h2: nxt_st.wave[i] = 1'b0;
                    4'h3: nxt_st.wave[i] = ~st_ff.wave[i];
                    default: nxt_st.wave[i] = st_ff.wave[i];
                endcase
            end
            nxt_st.cmp_out[i] = nxt_st.cmp_en[i] & (nxt_st.wave[i] ^ nxt_st.cmp_inv[i]);
            // capture: filter always shifts so switching it on needs no warm-up
            nxt_st.shreg[i] = {st_ff.shreg[i][`TCC_FILT_LEN-2:0], cap_i[i]};
            if (&st_ff.shreg[i]) begin
                nxt_st.filt[i] = 1'b1;
            end else if (~|st_ff.shreg[i]) begin
                nxt_st.filt[i] = 1'b0;
            end
            sig = st_ff.cap_filt[i] ? st_ff.filt[i] : cap_i[i];
            nxt_st.prev[i] = sig;
            case (edge_code(st_ff.cap_edge[i]))
                TCC_EDGE_RISE: ev[`TCC_ST_CAP_A + i] = sig & ~st_ff.prev[i];
                TCC_EDGE_FALL: ev[`TCC_ST_CAP_A + i] = ~sig & st_ff.prev[i];
                TCC_EDGE_BOTH: ev[`TCC_ST_CAP_A + i] = sig ^ st_ff.prev[i];
                default: ev[`TCC_ST_CAP_A + i] = 1'b0;
            endcase
            if (ev[`TCC_ST_CAP_A + i]) begin
                nxt_st.cap_val[i] = count_i;
            end
        end
        // a new event wins over a clear in the same cycle
        nxt_st.status = (st_ff.status & ~clr) | ev;
        nxt_st.irq = |(nxt_st.status & nxt_st.int_en);
        if (rst_i) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    assign dat_o = st_ff.dat;
    assign ack_o = st_ff.ack;
    assign irq_o = st_ff.irq;
    assign cmp_out_o = st_ff.cmp_out;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence cap_a_rise_s;
        (edge_code(st_ff.cap_edge[0]) == TCC_EDGE_RISE) && !st_ff.cap_filt[0] && !st_ff.prev[0] && cap_i[0];
    endsequence

    sequence cap_a_taken_s;
        st_ff.cap_val[0] == $past(count_i) && st_ff.status[`TCC_ST_CAP_A];
    endsequence

    out_disabled_low_a: assert property (!st_ff.cmp_en[0] |-> !cmp_out_o[0])
        else $error("compare output a driven while disabled");

    out_invert_a: assert property (st_ff.cmp_en[1] |-> cmp_out_o[1] == (st_ff.wave[1] ^ st_ff.cmp_inv[1]))
        else $error("compare output b polarity wrong");

    mode_toggle_a: assert property ((st_ff.cmp_mode[0] == 4'h3 && count_i == st_ff.cmp_val[0] &&
        !st_ff.match_d[0]) |=> st_ff.wave[0] != $past(st_ff.wave[0]))
        else $error("toggle mode did not toggle on match");

    filter_change_a: assert property (st_ff.filt[0] != $past(st_ff.filt[0]) |->
        ($past(st_ff.shreg[0]) == 4'hf || $past(st_ff.shreg[0]) == 4'h0))
        else $error("filter output changed without agreement");

    filter_block_a: assert property ((st_ff.cap_filt[0] && st_ff.cap_edge[0] != 2'h0 &&
        st_ff.filt[0] == st_ff.prev[0] && st_ff.shreg[0] != 4'hf && st_ff.shreg[0] != 4'h0)
        [*2] |-> !ev[`TCC_ST_CAP_A])
        else $error("capture fired through filter on a glitch");

    edge_off_a: assert property (st_ff.cap_edge[1] == 2'h0 |-> !ev[`TCC_ST_CAP_B])
        else $error("capture b fired while disabled");

    capture_copy_a: assert property (cap_a_rise_s |=> cap_a_taken_s)
        else $error("capture a did not take counter value");

    cap_readonly_a: assert property ((req && we_i && hit(adr_i, `TCC_IDX_CAP_VAL_B) &&
        !ev[`TCC_ST_CAP_B]) |=> $stable(st_ff.cap_val[1]))
        else $error("write changed capture value b");

    cap_ro_a_a: assert property ((req && we_i && hit(adr_i, `TCC_IDX_CAP_VAL_A) &&
        !ev[`TCC_ST_CAP_A]) |=> $stable(st_ff.cap_val[0]))
        else $error("write changed capture value a");

    // an enable write in the arrival cycle may legally mask the interrupt
    compare_irq_a: assert property ((count_i == st_ff.cmp_val[1] && !st_ff.match_d[1] && st_ff.int_en[1] &&
        !(req && we_i && hit(adr_i, `TCC_IDX_INT_ENABLE))) |=> st_ff.status[`TCC_ST_CMP_B] ##0 irq_o)
        else $error("compare b match did not raise interrupt");

    capture_irq_a: assert property (ev[`TCC_ST_CAP_B] |=> st_ff.status[`TCC_ST_CAP_B] [*2]
        or (st_ff.status[`TCC_ST_CAP_B] ##1 1'b1))
        else $error("capture b event not flagged");

    sequence cap_b_fall_s;
        (edge_code(st_ff.cap_edge[1]) == TCC_EDGE_FALL) && !st_ff.cap_filt[1] && st_ff.prev[1] && !cap_i[1];
    endsequence

    sequence cap_b_taken_s;
        st_ff.cap_val[1] == $past(count_i) && st_ff.status[`TCC_ST_CAP_B];
    endsequence

    sequence filt_b_high_s;
        st_ff.shreg[1] == 4'hf;
    endsequence

    sequence filt_b_low_s;
        st_ff.shreg[1] == 4'h0;
    endsequence

    out_disabled_b_a: assert property (!st_ff.cmp_en[1] |-> !cmp_out_o[1])
        else $error("compare output b driven while disabled");

    out_polarity_a: assert property (st_ff.cmp_en[0] |->
        cmp_out_o[0] == (st_ff.wave[0] ^ st_ff.cmp_inv[0]))
        else $error("compare output a polarity wrong");

    mode_set_a: assert property ((st_ff.cmp_mode[0] == 4'h1 && count_i == st_ff.cmp_val[0] &&
        !st_ff.match_d[0]) |=> st_ff.wave[0])
        else $error("set mode did not raise the waveform");

    mode_clear_a: assert property ((st_ff.cmp_mode[0] == 4'h2 && count_i == st_ff.cmp_val[0] &&
        !st_ff.match_d[0]) |=> !st_ff.wave[0])
        else $error("clear mode did not lower the waveform");

    mode_hold_a: assert property (!(count_i == st_ff.cmp_val[0] && !st_ff.match_d[0]) |=>
        $stable(st_ff.wave[0]))
        else $error("waveform moved without a compare arrival");

    filter_rise_a: assert property (filt_b_high_s |=> st_ff.filt[1])
        else $error("filter b did not follow agreeing ones");

    filter_fall_a: assert property (filt_b_low_s |=> !st_ff.filt[1])
        else $error("filter b did not follow agreeing zeros");

    filter_hold_b_a: assert property ((st_ff.shreg[1] != 4'hf && st_ff.shreg[1] != 4'h0) |=>
        $stable(st_ff.filt[1]))
        else $error("filter b changed without agreement");

    capture_copy_b_a: assert property (cap_b_fall_s |=> cap_b_taken_s)
        else $error("capture b did not take counter value on falling edge");

    cap_a_off_a: assert property (st_ff.cap_edge[0] == 2'h0 |-> !ev[`TCC_ST_CAP_A])
        else $error("capture a fired while disabled");

    cap_a_hold_a: assert property (!ev[`TCC_ST_CAP_A] |=> $stable(st_ff.cap_val[0]))
        else $error("capture value a changed without a capture event");

    cap_b_hold_a: assert property (!ev[`TCC_ST_CAP_B] |=> $stable(st_ff.cap_val[1]))
        else $error("capture value b changed without a capture event");

    compare_flag_a: assert property ((count_i == st_ff.cmp_val[0] && !st_ff.match_d[0]) |=>
        st_ff.status[`TCC_ST_CMP_A])
        else $error("compare a arrival not flagged");

    capture_flag_a: assert property (ev[`TCC_ST_CAP_A] |=> st_ff.status[`TCC_ST_CAP_A])
        else $error("capture a event not flagged");

    status_sticky_a: assert property ((st_ff.status[`TCC_ST_CAP_A] && !clr[`TCC_ST_CAP_A]) |=>
        st_ff.status[`TCC_ST_CAP_A])
        else $error("capture a flag dropped without a clear");

    irq_level_a: assert property (irq_o == |(st_ff.status & st_ff.int_en))
        else $error("interrupt level does not follow enabled flags");

    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("acknowledge held for more than one cycle");

    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside acknowledge");

endmodule : tcc_channels

/* verification/tcc_gpio_model.sv */
// gpio pad model that drives the capture inputs
`timescale 1ns/10ps
module tcc_gpio_model (
    input wire logic clk_i,
    input wire logic [1:0] level_i,
    output logic [1:0] cap_o
);
    logic [1:0] pad_ff;
    // pads change on the clock edge so the block sees a synchronous level
    always_ff @(posedge clk_i) begin
        pad_ff <= level_i;
    end
    assign cap_o = pad_ff;
endmodule : tcc_gpio_model

/* verification/tb_top.sv */
// self-checking testbench of the capture/compare channels
`timescale 1ns/10ps
`include "tcc_defines.svh"
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [`TCC_ADR_W-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [15:0] count_i = 16'hffff;
    logic [1:0] pin_lvl = 2'h0;
    logic [1:0] cap_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic [1:0] cmp_out_o;
    int bad_count = 0;
    int check_count = 0;
    logic [31:0] rdat;
    logic [15:0] cexp;
    logic wave;
    logic [3:0] modes [5] = '{4'h1, 4'h3, 4'h3, 4'h5, 4'h2};
    logic [15:0] regs [8] = '{`TCC_IDX_CAP_VAL_A, `TCC_IDX_CAP_VAL_B, `TCC_IDX_CMP_VAL_A, `TCC_IDX_CMP_VAL_B,
        `TCC_IDX_CMP_CFG_A, `TCC_IDX_CMP_CFG_B, `TCC_IDX_CAP_CFG_A, `TCC_IDX_CAP_CFG_B};

    tcc_channels i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .count_i(count_i), .cap_i(cap_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .cmp_out_o(cmp_out_o));
    tcc_gpio_model i_gpio (.clk_i(clk_i), .level_i(pin_lvl), .cap_o(cap_i));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle; no latency assumed, the watchdog ends a hang
    task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] wd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'h3;
        dat_i <= {16'h0000, wd};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        wb(1'b0, idx, 16'h0000);
        chk(rdat, {16'h0000, exp});
    endtask : rd

    task automatic wt(input logic [15:0] idx, input logic [15:0] wd);
        wb(1'b1, idx, wd);
    endtask : wt

    task automatic pin(input int n, input logic [1:0] exp);
        repeat (n) @(posedge clk_i);
        chk(cmp_out_o, exp);
    endtask : pin

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (10000) @(posedge clk_i);
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rd(regs[i], 16'h0000);
        wt(`TCC_IDX_CMP_VAL_B, 16'h5a3c);
        rd(`TCC_IDX_CMP_VAL_B, 16'h5a3c);
        wt(`TCC_IDX_CMP_CFG_A, 16'hffff);
        rd(`TCC_IDX_CMP_CFG_A, 16'h801f);
        pin(2, 2'b01);
        wt(`TCC_IDX_CAP_CFG_B, 16'hffff);
        rd(`TCC_IDX_CAP_CFG_B, 16'h0160);
        wt(`TCC_IDX_CAP_VAL_A, 16'hffff);
        rd(`TCC_IDX_CAP_VAL_A, 16'h0000);
        wt(`TCC_IDX_CAP_VAL_B, 16'hffff);
        rd(`TCC_IDX_CAP_VAL_B, 16'h0000);
        rd(16'h4530, 16'h0000);
        wt(`TCC_IDX_CAP_CFG_B, 16'h0000);
        $display("test done: registers");
        for (int ch = 0; ch < 2; ch++) begin
            wave = 1'b0;
            wt(ch ? `TCC_IDX_CMP_VAL_B : `TCC_IDX_CMP_VAL_A, 16'(16'h0040 + ch));
            foreach (modes[m]) begin
                count_i <= 16'h0000;
                wt(ch ? `TCC_IDX_CMP_CFG_B : `TCC_IDX_CMP_CFG_A, {12'h800, modes[m]});
                count_i <= 16'(16'h0040 + ch);
                wave = (modes[m] == 1) ? 1'b1 : (modes[m] == 2) ? 1'b0 : (modes[m] == 3) ? !wave : wave;
                repeat (3) @(posedge clk_i);
                chk(cmp_out_o[ch], wave);
                rd(`TCC_IDX_INT_STATUS, 16'(1 << ch));
                wt(`TCC_IDX_INT_CLEAR, 16'h000f);
            end
            wt(ch ? `TCC_IDX_CMP_CFG_B : `TCC_IDX_CMP_CFG_A, 16'h8012);
            pin(2, 2'(1 << ch));
            wt(ch ? `TCC_IDX_CMP_CFG_B : `TCC_IDX_CMP_CFG_A, 16'h0012);
            pin(2, 2'b00);
        end
        wt(`TCC_IDX_INT_ENABLE, 16'h0001);
        count_i <= 16'h0040;
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wt(`TCC_IDX_INT_ENABLE, 16'h0002);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wt(`TCC_IDX_INT_CLEAR, 16'h0001);
        wt(`TCC_IDX_INT_ENABLE, 16'h0001);
        rd(`TCC_IDX_INT_STATUS, 16'h0000);
        chk(irq_o, 1'b0);
        wt(`TCC_IDX_INT_ENABLE, 16'h0002);
        count_i <= 16'h0041;
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b1);
        rd(`TCC_IDX_INT_STATUS, 16'h0002);
        wt(`TCC_IDX_INT_CLEAR, 16'h0002);
        chk(irq_o, 1'b0);
        $display("test done: compare");
        for (int ch = 0; ch < 2; ch++) begin
            cexp = 16'h0000;
            for (int e = 0; e < 4; e++) begin
                // odd codes run through the filter, so rise and both go filtered, off and fall unfiltered
                wt(ch ? `TCC_IDX_CAP_CFG_B : `TCC_IDX_CAP_CFG_A, {7'h00, 1'(e), 1'b0, 2'(e), 5'h00});
                count_i <= 16'(16'h1100 + e);
                pin_lvl[ch] <= 1'b1;
                repeat (10) @(posedge clk_i);
                count_i <= 16'(16'h2200 + e);
                pin_lvl[ch] <= 1'b0;
                repeat (10) @(posedge clk_i);
                if (e != 0) cexp = (e == 1) ? 16'h1101 : 16'(16'h2200 + e);
                rd(ch ? `TCC_IDX_CAP_VAL_B : `TCC_IDX_CAP_VAL_A, cexp);
                rd(`TCC_IDX_INT_STATUS, (e != 0) ? 16'(4 << ch) : 16'h0000);
                wt(`TCC_IDX_INT_CLEAR, 16'h000f);
            end
            wt(ch ? `TCC_IDX_CAP_CFG_B : `TCC_IDX_CAP_CFG_A, 16'h0160);
            count_i <= 16'h3300;
            pin_lvl[ch] <= 1'b1;
            repeat (2) @(posedge clk_i);
            pin_lvl[ch] <= 1'b0;
            repeat (10) @(posedge clk_i);
            rd(ch ? `TCC_IDX_CAP_VAL_B : `TCC_IDX_CAP_VAL_A, cexp);
            wt(ch ? `TCC_IDX_CAP_CFG_B : `TCC_IDX_CAP_CFG_A, 16'h0020);
            count_i <= 16'h4400;
            pin_lvl[ch] <= 1'b1;
            @(posedge clk_i);
            pin_lvl[ch] <= 1'b0;
            repeat (6) @(posedge clk_i);
            rd(ch ? `TCC_IDX_CAP_VAL_B : `TCC_IDX_CAP_VAL_A, 16'h4400);
            rd(`TCC_IDX_INT_STATUS, 16'(4 << ch));
            wt(`TCC_IDX_INT_CLEAR, 16'h000f);
        end
        $display("test done: capture");
        stop_test();
    end
endmodule : tb_top
